// *** csi_pkg.sv ***
// Purpose: Shared constants and types for the stack and interrupt control block
// Assumes: Single CPU clock, no internal clock division
// Notes: Vector layout and cycle counts are held here once
package csi_pkg;

  // I/O space addresses of the stack pointer bytes
  localparam logic [5:0] SP_LOW_ADDR = 6'h3D;
  localparam logic [5:0] SP_HIGH_ADDR = 6'h3E;
  localparam logic [7:0] SP_RESET = 8'h00;

  // Status register layout: only the global enable bit lives here
  localparam int GIE_BIT = 7;

  // Timing in CPU clock cycles
  localparam logic [3:0] ENTRY_CYC = 4'h4;
  localparam logic [3:0] SLEEP_EXTRA_CYC = 4'h4;
  localparam logic [3:0] RETURN_CYC = 4'h4;

  // Stack pointer steps
  localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
  localparam logic [15:0] SP_STEP_ADDR = 16'h0002;

  // Vector table: slot 0 is reset, source i sits in slot i+1
  localparam int VEC_STRIDE = 2;

  // Sequencer states
  typedef enum logic [1:0] {
    CSI_RUN = 2'b00,
    CSI_ENTRY = 2'b01,
    CSI_RETURN = 2'b10
  } csi_state_t;

  // Instruction sequencer report, valid when done is high
  typedef struct packed {
    logic done;
    logic push;
    logic pop;
    logic call;
    logic ret;
    logic return_from_interrupt_instr;
    logic sei;
    logic global_disable_instr;
    logic sleeping;
  } csi_seq_t;

  // I/O register access port
  typedef struct packed {
    logic [5:0] addr;
    logic we;
    logic [7:0] wdata;
  } csi_io_t;

endpackage : csi_pkg

// *** csi_core.sv ***
// Purpose: Interrupt dispatch and hardware stack pointer of an 8-bit CPU core
// Assumes: Sequencer reports each retired instruction on seq.done; inputs synchronous to mclk
// Notes: Status register beyond the global enable bit belongs to the CPU datapath
module csi_core #(
  parameter int NSRC = 8,
  parameter int PCW = 15,
  parameter logic [NSRC-1:0] LEVEL_MASK = '0,
  parameter logic [PCW-1:0] BOOT_BASE = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire csi_pkg::csi_io_t io,
  output logic [7:0] io_rdata,
  input wire csi_pkg::csi_seq_t seq,
  input wire logic gie_we,
  input wire logic [7:0] gie_wdata,
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] src_level,
  input wire logic [NSRC-1:0] src_enable,
  input wire logic flag_clear_we,
  input wire logic [NSRC-1:0] flag_clear_data,
  input wire logic vector_select_bit,
  input wire logic boot_reset_fuse,
  input wire logic app_boot_lock_bit,
  input wire logic boot_section_lock_bit,
  input wire logic pc_in_boot,
  output logic [15:0] stack_pointer,
  output logic gie,
  output logic [NSRC-1:0] flags,
  output logic irq_busy,
  output logic irq_taken,
  output logic [PCW-1:0] vector_pc,
  output logic vector_valid,
  output logic [PCW-1:0] reset_vector,
  output logic return_done
);

  localparam int IW = (NSRC > 1) ? $clog2(NSRC) : 1;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] sp_high;
    logic [7:0] sp_low;
    logic gie;
    logic [NSRC-1:0] flag;
    logic hold;
    csi_pkg::csi_state_t state;
    logic [3:0] cnt;
    logic [PCW-1:0] vec;
    logic vec_valid;
    logic taken;
    logic ret_done;
  } csi_st_t;

  csi_st_t st_r;
  csi_st_t st_nxt;

  // Lowest requesting index has the highest priority
  function automatic logic [IW-1:0] csi_first(input logic [NSRC-1:0] req);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = IW'(i);
      end
    end
    return idx;
  endfunction : csi_first

  // Table base chosen by the select bit or fuse
  function automatic logic [PCW-1:0] csi_base(input logic to_boot);
    return to_boot ? BOOT_BASE : '0;
  endfunction : csi_base

  // Pointer moved up or down by one step
  function automatic logic [15:0] csi_sp_move(input logic [15:0] sp, input logic up,
    input logic [15:0] step);
    return up ? sp + step : sp - step;
  endfunction : csi_sp_move

  logic [15:0] sp_cur;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] req;
  logic lock_block;
  logic may_take;
  logic [IW-1:0] win;

  // Request vector: latched flags or live level conditions
  always_comb
  begin
    sp_cur = {st_r.sp_high, st_r.sp_low};
    for (int i = 0; i < NSRC; i++)
    begin
      pend[i] = LEVEL_MASK[i] ? src_level[i] : st_r.flag[i];
    end
    req = pend & src_enable;
    // Boot lock bits mask interrupts by where the PC runs
    lock_block = (app_boot_lock_bit && !pc_in_boot) || (boot_section_lock_bit && pc_in_boot);
    // Accept only at an instruction boundary with every gate open
    may_take = seq.done && st_r.state == csi_pkg::CSI_RUN && st_r.gie && !seq.global_disable_instr
      && !st_r.hold && !seq.sei && !seq.return_from_interrupt_instr && !lock_block && |req;
    // Fixed priority, lowest index first
    win = csi_first(req);
  end

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    // One-cycle pulses drop unless set again below
    st_nxt.vec_valid = 1'b0;
    st_nxt.taken = 1'b0;
    st_nxt.ret_done = 1'b0;

    // Software write-one clears a flag; zero bits leave it alone
    if (flag_clear_we)
    begin
      st_nxt.flag = st_nxt.flag & ~flag_clear_data;
    end

    // Software write of the status register global enable bit
    if (gie_we)
    begin
      st_nxt.gie = gie_wdata[csi_pkg::GIE_BIT];
    end

    // Hold lapses once one instruction of the program has retired
    if (seq.done && st_r.state == csi_pkg::CSI_RUN)
    begin
      st_nxt.hold = 1'b0;
    end

    // Stack pointer moves for ordinary instructions
    if (seq.done && st_r.state == csi_pkg::CSI_RUN)
    begin
      if (seq.push)
      begin
        {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move(sp_cur, 1'b0, csi_pkg::SP_STEP_BYTE);
      end
      else if (seq.pop)
      begin
        {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move(sp_cur, 1'b1, csi_pkg::SP_STEP_BYTE);
      end
      else if (seq.call)
      begin
        {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move(sp_cur, 1'b0, csi_pkg::SP_STEP_ADDR);
      end
      else if (seq.ret)
      begin
        {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move(sp_cur, 1'b1, csi_pkg::SP_STEP_ADDR);
      end
      // Global enable instructions; sei also arms the hold
      if (seq.global_disable_instr)
      begin
        st_nxt.gie = 1'b0;
      end
      if (seq.sei)
      begin
        st_nxt.gie = 1'b1;
        st_nxt.hold = 1'b1;
      end
    end

    // Sequencer: entry, return and normal running
    case (st_r.state)
      csi_pkg::CSI_RUN:
      begin
        if (may_take)
        begin
          // Accept on top of the retired instruction's own pointer move
          st_nxt.state = csi_pkg::CSI_ENTRY;
          st_nxt.cnt = seq.sleeping ? csi_pkg::ENTRY_CYC + csi_pkg::SLEEP_EXTRA_CYC - 4'h1
            : csi_pkg::ENTRY_CYC - 4'h1;
          st_nxt.gie = 1'b0;
          st_nxt.taken = 1'b1;
          {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move({st_nxt.sp_high, st_nxt.sp_low}, 1'b0,
            csi_pkg::SP_STEP_ADDR);
          st_nxt.vec = csi_base(vector_select_bit)
            + PCW'((int'(win) + 1) * csi_pkg::VEC_STRIDE);
          // Level sources carry no flag, so nothing is cleared
          if (!LEVEL_MASK[win])
          begin
            st_nxt.flag[win] = 1'b0;
          end
        end
        else if (seq.done && seq.return_from_interrupt_instr)
        begin
          // Return: pop the address now, restore global enable at the end
          st_nxt.state = csi_pkg::CSI_RETURN;
          st_nxt.cnt = csi_pkg::RETURN_CYC - 4'h1;
          {st_nxt.sp_high, st_nxt.sp_low} = csi_sp_move({st_nxt.sp_high, st_nxt.sp_low}, 1'b1,
            csi_pkg::SP_STEP_ADDR);
        end
      end
      csi_pkg::CSI_ENTRY:
      begin
        // Vector handed over in the last entry cycle
        st_nxt.cnt = st_r.cnt - 4'h1;
        if (st_r.cnt == 4'h1)
        begin
          st_nxt.vec_valid = 1'b1;
        end
        if (st_r.cnt == 4'h0)
        begin
          st_nxt.state = csi_pkg::CSI_RUN;
        end
      end
      csi_pkg::CSI_RETURN:
      begin
        // Global enable and the hold come back together
        st_nxt.cnt = st_r.cnt - 4'h1;
        if (st_r.cnt == 4'h1)
        begin
          st_nxt.gie = 1'b1;
          st_nxt.hold = 1'b1;
          st_nxt.ret_done = 1'b1;
          st_nxt.state = csi_pkg::CSI_RUN;
        end
      end
      default:
      begin
        st_nxt.state = csi_pkg::CSI_RUN;
      end
    endcase

    // Direct I/O writes of the pointer bytes win over any sequencer move
    if (io.we && io.addr == csi_pkg::SP_LOW_ADDR)
    begin
      st_nxt.sp_low = io.wdata;
    end
    if (io.we && io.addr == csi_pkg::SP_HIGH_ADDR)
    begin
      st_nxt.sp_high = io.wdata;
    end

    // New events win over any clear in the same cycle
    st_nxt.flag = st_nxt.flag | (src_event & ~LEVEL_MASK);
  end

  // State register, frozen while ce is low
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{sp_high: csi_pkg::SP_RESET, sp_low: csi_pkg::SP_RESET, gie: 1'b0, flag: '0,
        hold: 1'b0, state: csi_pkg::CSI_RUN, cnt: 4'h0, vec: '0, vec_valid: 1'b0,
        taken: 1'b0, ret_done: 1'b0};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // I/O read mux; other addresses read zero
  always_comb
  begin
    case (io.addr)
      csi_pkg::SP_LOW_ADDR: io_rdata = st_r.sp_low;
      csi_pkg::SP_HIGH_ADDR: io_rdata = st_r.sp_high;
      default: io_rdata = 8'h00;
    endcase
  end

  // Outputs; the status register is never pushed by this block
  assign stack_pointer = sp_cur;
  assign gie = st_r.gie;
  assign flags = st_r.flag;
  assign irq_busy = st_r.state != csi_pkg::CSI_RUN;
  assign irq_taken = st_r.taken;
  assign vector_pc = st_r.vec;
  assign vector_valid = st_r.vec_valid;
  assign return_done = st_r.ret_done;
  assign reset_vector = csi_base(boot_reset_fuse);

endmodule : csi_core

// *** csi_assertions.sv ***
// Purpose: Port checks for the stack and interrupt block
// Assumes: ce high, no sleep while an entry runs
// Notes: Bound to csi_core from the testbench
module csi_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire csi_pkg::csi_io_t io,
  input wire csi_pkg::csi_seq_t seq,
  input wire logic [15:0] stack_pointer,
  input wire logic gie,
  input wire logic irq_busy,
  input wire logic irq_taken,
  input wire logic vector_valid,
  input wire logic return_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Accepted boundary and expected pointer after the retired instruction
  logic acc;
  logic [15:0] sp_step;
  assign acc = seq.done && !irq_busy && !io.we;
  assign sp_step = seq.push ? stack_pointer - 16'h0001 : seq.pop ? stack_pointer + 16'h0001
    : seq.call ? stack_pointer - 16'h0002 : seq.ret ? stack_pointer + 16'h0002 : stack_pointer;
  property p_take_gie; irq_taken |-> !gie; endproperty
  a_take_gie: assert property (p_take_gie) else $error("gie high after take");
  property p_take_sp; irq_taken && !$past(io.we) |-> stack_pointer == $past(sp_step) - 16'h0002; endproperty
  a_take_sp: assert property (p_take_sp) else $error("entry pointer step");
  property p_entry; irq_taken && !$past(seq.sleeping) |-> (irq_busy && !vector_valid) ##1 (irq_busy && !vector_valid)
    ##1 (irq_busy && !vector_valid) ##1 (irq_busy && vector_valid) ##1 !irq_busy; endproperty
  a_entry: assert property (p_entry) else $error("entry length");
  property p_return_from_interrupt_instr; acc && seq.return_from_interrupt_instr |=> stack_pointer == $past(stack_pointer) + 16'h0002
    ##3 (return_done && gie); endproperty
  a_return_from_interrupt_instr: assert property (p_return_from_interrupt_instr) else $error("return sequence");
  property p_cli; acc && seq.global_disable_instr |=> !irq_taken; endproperty
  a_cli: assert property (p_cli) else $error("take on disable");
  property p_sei; acc && seq.sei |=> !irq_taken; endproperty
  a_sei: assert property (p_sei) else $error("take on enable");
  property p_gie_off; !gie |=> !irq_taken; endproperty
  a_gie_off: assert property (p_gie_off) else $error("take without gie");
  property p_step; acc && !gie && (seq.push || seq.pop) |=> stack_pointer == $past(sp_step); endproperty
  a_step: assert property (p_step) else $error("push pop step");
endmodule : csi_assertions

// *** csi_sqm.sv ***
// Purpose: Sequencer model reporting retired instructions
// Assumes: op one-hot over push..cli, zero for a plain one
// Notes: Never reports during entry or return
module csi_sqm (
  input wire logic mclk,
  input wire logic go,
  input wire logic [6:0] op,
  input wire logic busy,
  output csi_pkg::csi_seq_t seq
);
  timeunit 1ns;
  timeprecision 1ps;
  // One done pulse per request
  always_ff @(posedge mclk)
    seq <= (go && !busy) ? {1'h1, op, 1'h0} : '0;
endmodule : csi_sqm

// *** csi_tb.sv ***
// Purpose: Self-checking bench for csi_core
// Assumes: 100 MHz mclk, one request at a time
// Notes: Lock and flag paths driven through side ports
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Boot section base for this bench; arbitrary value
  localparam logic [14:0] BOOT = 15'h1000;
  logic mclk = 0, resetn = 0, go = 0, gwe = 0, fcw = 0, lk = 0, vsb = 0, brf = 0, gie, bsy, tk, rdn;
  logic [6:0] op = '0;
  logic [7:0] gwd = '0, ev = '0, en = '0, fcd = '0, fl, rd;
  logic [14:0] vpc, rv;
  logic [15:0] sp;
  csi_pkg::csi_io_t io = '0;
  csi_pkg::csi_seq_t seq;
  int err_count = 0, n_tests = 0;
  // Clock
  always #5 mclk = ~mclk;
  csi_sqm sqm (.mclk(mclk), .go(go), .op(op), .busy(bsy), .seq(seq));
  csi_core #(.BOOT_BASE(BOOT)) dut (.mclk(mclk), .resetn(resetn), .ce(1'h1), .io(io), .io_rdata(rd),
    .seq(seq), .gie_we(gwe), .gie_wdata(gwd), .src_event(ev), .src_level(8'h00), .src_enable(en),
    .flag_clear_we(fcw), .flag_clear_data(fcd), .vector_select_bit(vsb), .boot_reset_fuse(brf),
    .app_boot_lock_bit(lk), .boot_section_lock_bit(lk), .pc_in_boot(1'h0), .stack_pointer(sp), .gie(gie),
    .flags(fl), .irq_busy(bsy), .irq_taken(tk), .vector_pc(vpc), .vector_valid(), .reset_vector(rv),
    .return_done(rdn));
  task chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task run(input logic [6:0] o);
    @(posedge mclk);
    op <= o;
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    @(posedge mclk);
    #1;
  endtask : run
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    io <= '{a, 1'h1, d};
    @(posedge mclk);
    io.we <= 1'h0;
    #1;
  endtask : wr
  task evp(input logic [7:0] v, e);
    @(posedge mclk);
    ev <= v;
    en <= e;
    @(posedge mclk);
    ev <= 8'h00;
    #1;
  endtask : evp
  task setg(input logic g, l);
    @(posedge mclk);
    gwe <= 1'h1;
    gwd <= {g, 7'h00};
    lk <= l;
    @(posedge mclk);
    gwe <= 1'h0;
    #1;
  endtask : setg
  task fclr(input logic [7:0] v);
    @(posedge mclk);
    fcw <= 1'h1;
    fcd <= v;
    @(posedge mclk);
    fcw <= 1'h0;
    #1;
  endtask : fclr
  task return_from_interrupt_instr_wait();
    repeat (3) @(posedge mclk);
    run(7'h04);
    repeat (3) @(posedge mclk);
    #1;
  endtask : return_from_interrupt_instr_wait
  task t_stack();
    chk("sp", sp, 16'h0000);
    wr(6'h3E, 8'h01);
    wr(6'h3D, 8'h80);
    chk("rd", {8'h00, rd}, 16'h0080);
    run(7'h40);
    chk("push", sp, 16'h017F);
    run(7'h10);
    chk("call", sp, 16'h017D);
    run(7'h20);
    chk("pop", sp, 16'h017E);
    run(7'h08);
    chk("ret", sp, 16'h0180);
  endtask : t_stack
  task t_irq();
    evp(8'h03, 8'h01);
    chk("flags", {8'h00, fl}, 16'h0003);
    run(7'h00);
    chk("nogie", {15'h0, tk}, 16'h0000);
    setg(1'h1, 1'h1);
    run(7'h00);
    chk("lock", {15'h0, tk}, 16'h0000);
    setg(1'h1, 1'h0);
    run(7'h00);
    chk("take", {15'h0, tk}, 16'h0001);
    chk("vec", {1'h0, vpc}, 16'h0002);
    chk("hwclr", {8'h00, fl}, 16'h0002);
    chk("gie", {15'h0, gie}, 16'h0000);
    chk("esp", sp, 16'h017E);
    evp(8'h00, 8'h03);
    return_from_interrupt_instr_wait();
    chk("rsp", sp, 16'h0180);
    chk("rgie", {14'h0, gie, rdn}, 16'h0003);
    run(7'h00);
    chk("hold", {15'h0, tk}, 16'h0000);
    run(7'h00);
    chk("vec1", {1'h0, vpc}, 16'h0004);
    return_from_interrupt_instr_wait();
  endtask : t_irq
  task t_flag();
    evp(8'h04, 8'h03);
    fclr(8'h01);
    chk("keep", {8'h00, fl}, 16'h0004);
    fclr(8'h04);
    chk("clr", {8'h00, fl}, 16'h0000);
  endtask : t_flag
  task t_boot();
    chk("rvec", {1'h0, rv}, 16'h0000);
    @(posedge mclk);
    brf <= 1'h1;
    vsb <= 1'h1;
    @(posedge mclk);
    #1;
    chk("rboot", {1'h0, rv}, {1'h0, BOOT});
  endtask : t_boot
  task t_cli();
    evp(8'h01, 8'h03);
    run(7'h01);
    chk("cli", {14'h0, tk, gie}, 16'h0000);
    run(7'h02);
    chk("sei", {15'h0, tk}, 16'h0000);
    run(7'h00);
    chk("after", {15'h0, tk}, 16'h0000);
    run(7'h40);
    chk("next", {15'h0, tk}, 16'h0001);
    chk("bvec", {1'h0, vpc}, {1'h0, BOOT} + 16'h0002);
    chk("psp", sp, 16'h017D);
  endtask : t_cli
  task print_verdict();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'h1;
    t_stack();
    t_irq();
    t_flag();
    t_boot();
    t_cli();
    print_verdict();
  end
  // Watchdog, run needs about 90 cycles
  initial
  begin
    repeat (2000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
endmodule : testbench
bind csi_core csi_assertions u_chk (.mclk(mclk), .resetn(resetn), .io(io), .seq(seq),
  .stack_pointer(stack_pointer), .gie(gie), .irq_busy(irq_busy), .irq_taken(irq_taken),
  .vector_valid(vector_valid), .return_done(return_done));
